// ### include/aabx_defines.svh
// Opcode patterns, field positions, flag positions and limits for the exec block.
// Assumes a 16-bit instruction word and an 8-bit status vector from the core.
// Functional notes
// [RULE_01] The add-with-carry opcode adds the accumulator, the file register and the carry flag and sends the sum to the chosen destination.
// [RULE_02] The add-with-carry opcode updates the negative, overflow, carry, digit-carry and zero flags from its result.
// [RULE_03] A destination bit of 0 sends a byte result to the accumulator, and 1 writes it back to the file register.
// [RULE_04] An access bit of 0 addresses the access bank, and 1 takes the bank from the bank select register.
// [RULE_05] With the extended set on and the access bit 0, a file address of 95 or below is an offset from the index pointer.
// [RULE_06] The AND-with-file opcode ANDs the accumulator with the file register, sends the result to the destination and sets negative and zero.
// [RULE_07] An assembler form without a destination defaults to writing the file register back.
// [RULE_08] Branch on carry is taken only when carry is 1, and it changes no flag.
// [RULE_09] A taken branch loads the incremented program counter plus twice the signed offset.
// [RULE_10] A taken branch lasts two instruction cycles with a no-operation second cycle; an untaken one lasts one.
// [RULE_11] The bit-clear opcode clears the indexed bit of the file register and changes no other bit and no flag.
// [RULE_12] Each instruction cycle is four phases: decode, operand read, process, write.
`ifndef AABX_DEFINES_SVH
`define AABX_DEFINES_SVH
`define AABX_OP_ADDC 6'h08
`define AABX_OP_ANDF 6'h05
`define AABX_OP_ANDL 8'h0B
`define AABX_OP_BRC 8'hE2
`define AABX_OP_BCLR 4'h9
`define AABX_IDX_LIMIT 8'h5F
`define AABX_ACC_SPLIT 8'h60
`define AABX_ACC_HI_BANK 4'hF
`define AABX_FLG_C 0
`define AABX_FLG_DC 1
`define AABX_FLG_Z 2
`define AABX_FLG_OV 3
`define AABX_FLG_N 4
`define AABX_BIT_D 9
`define AABX_BIT_A 8
`endif

// ### include/aabx_pkg.sv
// Types shared by the exec block.
// Assumes the defines header is compiled alongside.
package aabx_pkg;
   typedef enum logic [3:0] {
      PH_DECODE = 4'b0001,
      PH_READ = 4'b0010,
      PH_PROC = 4'b0100,
      PH_WRITE = 4'b1000
   } aabx_phase_t;
   typedef enum logic [4:0] {
      OP_NONE = 5'b00001,
      OP_ADDC = 5'b00010,
      OP_ANDF = 5'b00100,
      OP_ANDL = 5'b01000,
      OP_BRC = 5'b10000
   } aabx_op_t;
endpackage

// ### design/aabx_addr_gen.sv
// File address generator for byte and bit operands.
// Assumes bank select and index pointer are stable through a cycle.
`timescale 1ns/1ps
`include "aabx_defines.svh"
module aabx_addr_gen (
   // Operand fields
   input wire logic [7:0] file_addr,
   input wire logic access_bit,
   // Core state
   input wire logic ext_set_en,
   input wire logic [3:0] bank_select_reg,
   input wire logic [11:0] index_ptr,
   // Result
   output logic [11:0] data_addr
);
   always_comb begin
      if (access_bit) begin
         data_addr = {bank_select_reg, file_addr}; // [RULE_04]
      end else if (ext_set_en && file_addr <= `AABX_IDX_LIMIT) begin
         data_addr = index_ptr + {4'h0, file_addr}; // [RULE_05]
      end else if (file_addr < `AABX_ACC_SPLIT) begin
         data_addr = {4'h0, file_addr}; // [RULE_04]
      end else begin
         data_addr = {`AABX_ACC_HI_BANK, file_addr};
      end
   end
endmodule

// ### design/aabx_exec.sv
// Executes add-with-carry, AND, branch-on-carry and bit-clear opcodes.
// Assumes the core presents the opcode at decode and returns file data in the read phase.
`timescale 1ns/1ps
`include "aabx_defines.svh"
module aabx_exec (
   // Clock and control
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // Instruction and core state
   input wire logic [15:0] instr,
   input wire logic ext_set_en,
   input wire logic [3:0] bank_select_reg,
   input wire logic [11:0] index_ptr,
   input wire logic [20:0] pc_in,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] status_in,
   input wire logic [7:0] file_rdata,
   // Outputs to core
   output logic [11:0] file_addr_q,
   output logic file_we_q,
   output logic [7:0] file_wdata_q,
   output logic acc_we_q,
   output logic [7:0] acc_wdata_q,
   output logic status_we_q,
   output logic [7:0] status_wdata_q,
   output logic pc_we_q,
   output logic [20:0] pc_wdata_q,
   output logic nop_cycle_q,
   output logic [3:0] phase_q
);
   aabx_pkg::aabx_phase_t ph_q, ph_d;
   aabx_pkg::aabx_op_t op_q, op_d;
   logic [15:0] ir_q, ir_d;
   logic bclr_q, bclr_d;
   logic [7:0] opnd_q, opnd_d;
   logic [7:0] res_q, res_d;
   logic [7:0] st_q, st_d;
   logic take_q, take_d;
   logic nop_q, nop_d;
   logic [11:0] addr_q;
   logic [11:0] addr_w;
   logic f_we_d, a_we_d, s_we_d, p_we_d;
   logic [7:0] f_wd_d, a_wd_d, s_wd_d;
   logic [20:0] p_wd_d;
   logic [8:0] sum9;
   logic [4:0] low5;
   logic [7:0] cl_mask;

   // Flags from an 8-bit result
   function automatic logic [7:0] nz_flags(input logic [7:0] st, input logic [7:0] r);
      logic [7:0] s;
      s = st;
      s[`AABX_FLG_N] = r[7];
      s[`AABX_FLG_Z] = (r == 8'h00);
      return s;
   endfunction

   // Fed from the next word so the address stands before the read phase
   aabx_addr_gen u_addr (
      .file_addr(ir_d[7:0]),
      .access_bit(ir_d[`AABX_BIT_A]),
      .ext_set_en(ext_set_en),
      .bank_select_reg(bank_select_reg),
      .index_ptr(index_ptr),
      .data_addr(addr_w)
   );

   always_comb begin
      sum9 = {1'b0, acc_in} + {1'b0, opnd_q} + {8'h00, status_in[`AABX_FLG_C]}; // [RULE_01]
      low5 = {1'b0, acc_in[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, status_in[`AABX_FLG_C]};
      cl_mask = ~(8'h01 << ir_q[11:9]);
   end

   always_comb begin
      ph_d = ph_q;
      op_d = op_q;
      ir_d = ir_q;
      bclr_d = bclr_q;
      opnd_d = opnd_q;
      res_d = res_q;
      st_d = st_q;
      take_d = take_q;
      nop_d = nop_q;
      f_we_d = 1'b0;
      a_we_d = 1'b0;
      s_we_d = 1'b0;
      p_we_d = 1'b0;
      f_wd_d = file_wdata_q;
      a_wd_d = acc_wdata_q;
      s_wd_d = status_wdata_q;
      p_wd_d = pc_wdata_q;
      case (ph_q) // [RULE_12]
         aabx_pkg::PH_DECODE: begin
            ph_d = aabx_pkg::PH_READ;
            ir_d = instr;
            bclr_d = 1'b0;
            op_d = aabx_pkg::OP_NONE;
            if (nop_q) begin
               // Idle cycle after a taken branch; flag holds to its write edge
               nop_d = 1'b1; // [RULE_10]
            end else if (instr[15:10] == `AABX_OP_ADDC) begin
               op_d = aabx_pkg::OP_ADDC;
            end else if (instr[15:10] == `AABX_OP_ANDF) begin
               op_d = aabx_pkg::OP_ANDF;
            end else if (instr[15:8] == `AABX_OP_ANDL) begin
               op_d = aabx_pkg::OP_ANDL;
            end else if (instr[15:8] == `AABX_OP_BRC) begin
               op_d = aabx_pkg::OP_BRC;
            end else if (instr[15:12] == `AABX_OP_BCLR) begin
               bclr_d = 1'b1;
            end
         end
         aabx_pkg::PH_READ: begin
            ph_d = aabx_pkg::PH_PROC;
            opnd_d = (op_q == aabx_pkg::OP_ANDL) ? ir_q[7:0] : file_rdata;
         end
         aabx_pkg::PH_PROC: begin
            ph_d = aabx_pkg::PH_WRITE;
            st_d = status_in;
            take_d = 1'b0;
            case (op_q)
               aabx_pkg::OP_ADDC: begin
                  res_d = sum9[7:0];
                  st_d = nz_flags(status_in, sum9[7:0]); // [RULE_02]
                  st_d[`AABX_FLG_C] = sum9[8];
                  st_d[`AABX_FLG_DC] = low5[4];
                  st_d[`AABX_FLG_OV] = (acc_in[7] == opnd_q[7]) && (sum9[7] != acc_in[7]);
               end
               aabx_pkg::OP_ANDF, aabx_pkg::OP_ANDL: begin
                  res_d = acc_in & opnd_q; // [RULE_06]
                  st_d = nz_flags(status_in, acc_in & opnd_q);
               end
               aabx_pkg::OP_BRC: begin
                  take_d = status_in[`AABX_FLG_C]; // [RULE_08]
               end
               default: begin
                  res_d = opnd_q & cl_mask; // [RULE_11]
               end
            endcase
         end
         aabx_pkg::PH_WRITE: begin
            ph_d = aabx_pkg::PH_DECODE;
            nop_d = 1'b0;
            case (op_q)
               aabx_pkg::OP_ADDC, aabx_pkg::OP_ANDF: begin
                  // An omitted destination is already a set d bit in the word
                  if (ir_q[`AABX_BIT_D]) begin // [RULE_07]
                     f_we_d = 1'b1; // [RULE_03]
                     f_wd_d = res_q;
                  end else begin
                     a_we_d = 1'b1; // [RULE_03]
                     a_wd_d = res_q;
                  end
                  s_we_d = 1'b1;
                  s_wd_d = st_q;
               end
               aabx_pkg::OP_ANDL: begin
                  a_we_d = 1'b1;
                  a_wd_d = res_q;
                  s_we_d = 1'b1;
                  s_wd_d = st_q;
               end
               aabx_pkg::OP_BRC: begin
                  if (take_q) begin
                     // pc_in is already past this word
                     p_we_d = 1'b1; // [RULE_09]
                     p_wd_d = pc_in + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
                     nop_d = 1'b1; // [RULE_10]
                  end
               end
               default: begin
                  if (bclr_q) begin
                     f_we_d = 1'b1; // [RULE_11]
                     f_wd_d = res_q;
                  end
               end
            endcase
         end
         default: begin
            ph_d = aabx_pkg::PH_DECODE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ph_q <= aabx_pkg::PH_DECODE;
         op_q <= aabx_pkg::OP_NONE;
         ir_q <= 16'h0000;
         bclr_q <= 1'b0;
         opnd_q <= 8'h00;
         res_q <= 8'h00;
         st_q <= 8'h00;
         take_q <= 1'b0;
         nop_q <= 1'b0;
         addr_q <= 12'h000;
         file_we_q <= 1'b0;
         file_wdata_q <= 8'h00;
         acc_we_q <= 1'b0;
         acc_wdata_q <= 8'h00;
         status_we_q <= 1'b0;
         status_wdata_q <= 8'h00;
         pc_we_q <= 1'b0;
         pc_wdata_q <= 21'h00_0000;
      end else if (clk_en) begin
         ph_q <= ph_d;
         op_q <= op_d;
         ir_q <= ir_d;
         bclr_q <= bclr_d;
         opnd_q <= opnd_d;
         res_q <= res_d;
         st_q <= st_d;
         take_q <= take_d;
         nop_q <= nop_d;
         addr_q <= addr_w;
         file_we_q <= f_we_d;
         file_wdata_q <= f_wd_d;
         acc_we_q <= a_we_d;
         acc_wdata_q <= a_wd_d;
         status_we_q <= s_we_d;
         status_wdata_q <= s_wd_d;
         pc_we_q <= p_we_d;
         pc_wdata_q <= p_wd_d;
      end
   end

   assign file_addr_q = addr_q;
   assign nop_cycle_q = nop_q;
   assign phase_q = ph_q;

   a_branch_flags: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_08]
      pc_we_q |-> !status_we_q)
      else $error("Branch wrote status");
   a_branch_nop: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_10]
      (pc_we_q && clk_en) |=> nop_cycle_q)
      else $error("Taken branch without idle cycle");
   a_dest_excl: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_03]
      !(file_we_q && acc_we_q))
      else $error("Both destinations written");
   a_phase_walk: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_12]
      (clk_en && phase_q == 4'b0001) |=> (phase_q == 4'b0010))
      else $error("Decode not followed by read");
   a_write_phase: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_12]
      (file_we_q || acc_we_q || pc_we_q) |-> (phase_q == 4'b0001))
      else $error("Write outside write phase");
   a_and_zero: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_06]
      (acc_we_q && op_q == aabx_pkg::OP_ANDL) |->
      (status_wdata_q[`AABX_FLG_Z] == (acc_wdata_q == 8'h00)))
      else $error("Zero flag mismatch");
   a_bclr_bit: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_11]
      (file_we_q && bclr_q) |-> (file_wdata_q[ir_q[11:9]] == 1'b0))
      else $error("Bit not cleared");
   a_add_neg: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_02]
      (status_we_q && op_q == aabx_pkg::OP_ADDC) |->
      (status_wdata_q[`AABX_FLG_N] == res_q[7]))
      else $error("Negative flag mismatch");

   // Destination routing, banked address, flag and bit-clear checks
   a_add_zero: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_02]
      (status_we_q && op_q == aabx_pkg::OP_ADDC) |->
      (status_wdata_q[`AABX_FLG_Z] == (res_q == 8'h00)))
      else $error("Add zero flag mismatch");
   a_and_neg: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_06]
      (status_we_q && op_q == aabx_pkg::OP_ANDF) |->
      (status_wdata_q[`AABX_FLG_N] == res_q[7]))
      else $error("AND negative flag mismatch");
   a_file_dest: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_03]
      (file_we_q && !bclr_q) |-> ir_q[`AABX_BIT_D])
      else $error("File written with d clear");
   a_acc_dest: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_03]
      (acc_we_q && op_q != aabx_pkg::OP_ANDL) |-> !ir_q[`AABX_BIT_D])
      else $error("Accumulator written with d set");
   a_bank_addr: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_04]
      (phase_q == 4'b0010 && ir_q[`AABX_BIT_A]) |->
      (file_addr_q == {bank_select_reg, ir_q[7:0]}))
      else $error("Banked address mismatch");
   a_bclr_noflag: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_11]
      (file_we_q && bclr_q) |-> !status_we_q)
      else $error("Bit clear wrote status");
   a_bclr_others: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_11]
      (file_we_q && bclr_q) |-> ((file_wdata_q | ~cl_mask) == (opnd_q | ~cl_mask)))
      else $error("Bit clear changed other bits");

   // Branch and cycle checks
   a_brc_noflag: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_08]
      status_we_q |-> (op_q != aabx_pkg::OP_BRC))
      else $error("Branch changed flags");
   a_pc_taken: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_09]
      pc_we_q |-> (op_q == aabx_pkg::OP_BRC && take_q))
      else $error("PC written without taken branch");
   a_nop_untaken: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_10]
      (clk_en && phase_q == 4'b1000 && op_q == aabx_pkg::OP_BRC && !take_q) |=>
      !nop_cycle_q)
      else $error("Untaken branch got idle cycle");
   a_nop_quiet: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_10]
      (clk_en && nop_cycle_q && phase_q == 4'b1000) |=>
      !(file_we_q || acc_we_q || status_we_q || pc_we_q))
      else $error("Idle cycle wrote something");
   a_strobe_pulse: assert property (@(posedge clk_sys) disable iff (reset) // [RULE_12]
      (clk_en && (file_we_q || acc_we_q || status_we_q || pc_we_q)) |=>
      !(file_we_q || acc_we_q || status_we_q || pc_we_q))
      else $error("Write strobe longer than one cycle");
endmodule

// ### sim/aabx_mem_model.sv
// Data memory model that answers the exec block's file reads and writes.
// Assumes the block samples read data in its read phase and strobes writes for one cycle.
`timescale 1ns/1ps
module aabx_mem_model (
   // Clock
   input wire logic clk_sys,
   // Port from exec block
   input wire logic [11:0] file_addr_q,
   input wire logic file_we_q,
   input wire logic [7:0] file_wdata_q,
   // Read data back
   output logic [7:0] file_rdata
);
   logic [7:0] mem [0:4095];
   // Combinational read, so a stale address shows the wrong byte at once
   assign file_rdata = mem[file_addr_q];
   always @(posedge clk_sys) begin
      if (file_we_q) begin
         mem[file_addr_q] <= file_wdata_q;
      end
   end
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i * 37);
      end
   end
endmodule

// ### sim/add_and_branch_bitclear_exec_test.sv
// Self-checking bench for the exec block with a data memory model beside it.
// Assumes one instruction per four enabled edges and strobes in the next decode phase.
`timescale 1ns/1ps
module add_and_branch_bitclear_exec_test;
   logic clk_sys = 1'b0, reset, clk_en, ext_set_en, nop_next;
   logic [15:0] instr;
   logic [3:0] bank_select_reg, phase_q;
   logic [11:0] index_ptr, file_addr_q;
   logic [20:0] pc_in, pc_wdata_q;
   logic [7:0] acc_in, status_in, file_rdata, file_wdata_q, acc_wdata_q, status_wdata_q;
   logic file_we_q, acc_we_q, status_we_q, pc_we_q, nop_cycle_q;
   logic [31:0] seed;
   logic [15:0] cor [12] = '{16'h2105, 16'h225F, 16'h2060, 16'h14FF, 16'h1633, 16'h0B5F,
      16'hE280, 16'h0BFF, 16'hE27F, 16'h9E10, 16'h9123, 16'hFFFF};
   logic [15:0] ob [5] = '{16'h2000, 16'h1400, 16'h0B00, 16'hE200, 16'h9000};
   logic [15:0] mk [5] = '{16'h03FF, 16'h03FF, 16'h00FF, 16'h00FF, 16'h0FFF};
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   aabx_exec u_dut (.clk_sys, .reset, .clk_en, .instr, .ext_set_en, .bank_select_reg,
      .index_ptr, .pc_in, .acc_in, .status_in, .file_rdata, .file_addr_q, .file_we_q,
      .file_wdata_q, .acc_we_q, .acc_wdata_q, .status_we_q, .status_wdata_q, .pc_we_q,
      .pc_wdata_q, .nop_cycle_q, .phase_q);
   aabx_mem_model u_mem (.clk_sys, .file_addr_q, .file_we_q, .file_wdata_q, .file_rdata);
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic logic [11:0] ea_f(input logic [7:0] f, input logic a);
      if (a) return {bank_select_reg, f};
      if (ext_set_en && f <= 8'h5F) return index_ptr + 12'(f);
      return {(f < 8'h60) ? 4'h0 : 4'hF, f};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Runs one instruction from a decode-phase falling edge to the next
   task automatic run(input logic [15:0] ins, input logic [1:0] cm);
      logic [11:0] ea;
      logic [8:0] s;
      logic [7:0] fv, r;
      logic [4:0] fl;
      logic [3:0] we;
      logic [20:0] pe;
      logic nop, stl, isad, isan, isal, isbc, isbr;
      nop = nop_next;
      nop_next = 0;
      isad = ins[15:10] == 6'h08;
      isan = ins[15:10] == 6'h05;
      isal = ins[15:8] == 8'h0B;
      isbr = ins[15:8] == 8'hE2;
      isbc = ins[15:12] == 4'h9;
      instr = ins;
      acc_in = 8'(rnd());
      status_in = 8'(rnd());
      if (cm[1]) status_in[0] = cm[0];
      pc_in = 21'(rnd());
      {ext_set_en, bank_select_reg, index_ptr} = 17'(rnd());
      stl = (rnd() & 32'h0000_0007) == 0;
      ea = ea_f(ins[7:0], ins[8]);
      fv = 0;
      we = 0;
      r = 0;
      pe = 0;
      fl = status_in[4:0];
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_sys);
         if (i == 0) begin
            // Poke after the previous write has landed
            fv = 8'(rnd());
            u_mem.mem[ea] = fv;
            chk(nop_cycle_q, nop);
            if (!nop && (isad || isan || isbc)) chk(file_addr_q, ea);
            if (stl) begin
               clk_en = 0;
               repeat (3) @(negedge clk_sys);
               chk(phase_q, 4'h2);
               clk_en = 1;
            end
         end
         chk(phase_q, 4'h1 << ((i + 1) % 4));
      end
      if (!nop) begin
         if (isad) begin
            s = 9'(acc_in) + 9'(fv) + 9'(status_in[0]);
            r = s[7:0];
            fl = {r[7], (acc_in[7] == fv[7]) && (r[7] != acc_in[7]), r == 0,
               5'(acc_in[3:0]) + 5'(fv[3:0]) + 5'(status_in[0]) > 5'h0F, s[8]};
            we = {~ins[9], ins[9], 2'b10};
         end else if (isan || isal) begin
            r = acc_in & (isal ? ins[7:0] : fv);
            fl[4] = r[7];
            fl[2] = r == 0;
            we = isal ? 4'b1010 : {~ins[9], ins[9], 2'b10};
         end else if (isbc) begin
            r = fv & ~(8'h01 << ins[11:9]);
            we = 4'b0100;
         end else if (isbr && status_in[0]) begin
            pe = pc_in + {{12{ins[7]}}, ins[7:0], 1'b0};
            we = 4'b0001;
            nop_next = 1;
         end
      end
      chk({acc_we_q, file_we_q, status_we_q, pc_we_q}, we);
      if (we[3]) chk(acc_wdata_q, r);
      if (we[2]) chk(file_wdata_q, r);
      if (we[1]) chk(status_wdata_q[4:0], fl);
      if (we[0]) chk(pc_wdata_q, pe);
   endtask
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Ceiling well above the at most 2,194 cycles the tests need
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      seed = 32'h0000_40B6;
      {clk_en, nop_next, instr, ext_set_en, bank_select_reg, index_ptr} = '0;
      {pc_in, acc_in, status_in} = '0;
      reset = 1;
      clk_en = 1;
      repeat (10) @(negedge clk_sys);
      reset = 0;
      for (int i = 0; i < 12; i++) begin
         run(cor[i], (i == 6) ? 2'b11 : (i == 8) ? 2'b10 : 2'b00);
      end
      $display("Test corners done");
      for (int i = 0; i < 300; i++) begin
         int k;
         k = int'(rnd() % 5);
         run(ob[k] | (mk[k] & 16'(rnd())), 2'b00);
      end
      $display("Test random done");
      stop_test();
   end
endmodule
